// *** src/mdd_map.svh ***
// constants of the multiply/divide execution datapath
`ifndef MDD_MAP_SVH
`define MDD_MAP_SVH
`define MDD_NREGS 32'h20
`define MDD_DIV_SKIP8 6'h17
`define MDD_DIV_SKIP16 6'h0f
`define MDD_DIV_SKIP24 6'h07
`define MDD_DIV_SKIP32 6'h00
`define MDD_DIV_RPT8 6'h0b
`define MDD_DIV_RPT16 6'h12
`define MDD_DIV_RPT24 6'h19
`define MDD_DIV_RPT32 6'h20
`define MDD_DIV_BITS 6'h20
`endif

// *** src/mdd_pkg.sv ***
// types of the multiply/divide execution datapath
package mdd_pkg;
   typedef enum logic [4:0] {
      OP_NOP, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_NOR, OP_SLL, OP_SRL,
      OP_SRA, OP_CNT_ZERO, OP_CNT_ONE, OP_LOAD, OP_STORE, OP_RD_UPPER,
      OP_RD_BOTTOM, OP_PROD_PAIR, OP_PROD_PAIR_U, OP_ACC_ADD, OP_ACC_ADD_U,
      OP_ACC_SUB, OP_ACC_SUB_U, OP_PROD_GPR, OP_QUOT, OP_QUOT_U
   } mdd_op_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_MUL2 = 3'b010,
      ST_DIV = 3'b100
   } mdd_state_t;
   typedef struct packed {
      logic valid;
      mdd_op_t op;
      logic [4:0] src_a;
      logic [4:0] src_b;
      logic [4:0] dst;
      logic [15:0] imm;
   } mdd_issue_t;
   typedef struct packed {
      logic valid;
      logic [4:0] idx;
      logic [31:0] data;
   } mdd_wb_t;
endpackage : mdd_pkg

// *** src/mdd_datapath.sv ***
// integer execution datapath with multiply/divide unit
`timescale 1ns/1ns
`default_nettype none
// Operation
// - thirty-two 32-bit general registers for integer work and addresses
// - two read ports, one write port, results bypassed to the next op
// - logical, shift, add and subtract finish in one cycle
// - own 32-bit adder forms load and store data addresses
// - leading-bit detector serves count zeros and count ones
// - muldiv unit advances on its own, whatever the integer pipeline does
// - 32x16 multiplier; one pass for 16-bit b, two passes otherwise
// - pass count is chosen from source b alone
// - short multiplies issue every cycle; long ones every other cycle
// - division yields one quotient bit per clock
// - early-in skips 23, 15 or 7 steps for narrow dividends
// - muldiv ops issued during division stall until it finishes
// - pair and accumulate ops take 1/1 or 2/2 cycles
// - product to register takes 2/1 or 3/2 cycles
// - division takes 11/11, 18/18, 25/25 or 32/32 cycles
// - results land in upper and bottom registers, read back by two ops
// - product to register writes the low word straight to a register
// - accumulate add adds the product to the upper/bottom pair
// - accumulate sub subtracts the product from the upper/bottom pair
`include "mdd_map.svh"
module mdd_datapath
   import mdd_pkg::*;
#(
   parameter int unsigned NREGS = `MDD_NREGS
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire mdd_issue_t iss_i,
   output logic mdu_stall_o,
   output logic port_stall_o,
   output var mdd_wb_t wb_o,
   output logic addr_valid_o,
   output logic addr_store_o,
   output logic [31:0] data_addr_o
);
   function automatic logic [31:0] rd_port(input logic [4:0] idx, input mdd_wb_t wb,
                                           input logic [31:0] mem);
      rd_port = (wb.valid && wb.idx == idx) ? wb.data : mem;
   endfunction : rd_port

   function automatic logic [5:0] lead_cnt(input logic [31:0] x);
      lead_cnt = 6'h20;
      for (int i = 0; i < 32; i++) begin
         if (x[i]) lead_cnt = 6'(31 - i);
      end
   endfunction : lead_cnt

   // booth recoding is left to synthesis; one pass is a signed 33x17 product
   function automatic logic [63:0] mul_pass(input logic [32:0] a, input logic [16:0] b);
      logic signed [49:0] p;
      p = $signed(a) * $signed(b);
      mul_pass = {{14{p[49]}}, p};
   endfunction : mul_pass

   function automatic logic [63:0] hilo_upd(input mdd_op_t op, input logic [63:0] acc,
                                            input logic [63:0] p);
      if (op == OP_ACC_ADD || op == OP_ACC_ADD_U) hilo_upd = acc + p;
      else if (op == OP_ACC_SUB || op == OP_ACC_SUB_U) hilo_upd = acc - p;
      else hilo_upd = p;
   endfunction : hilo_upd

   function automatic logic [64:0] div_step(input logic [32:0] r, input logic [31:0] q,
                                            input logic [31:0] d);
      logic [32:0] t;
      logic b;
      t = {r[31:0], q[31]};
      b = t >= {1'b0, d};
      if (b) t = t - {1'b0, d};
      div_step = {t, q[30:0], b};
   endfunction : div_step

   function automatic logic hilo_op(input mdd_op_t op);
      hilo_op = op inside {OP_PROD_PAIR, OP_PROD_PAIR_U, OP_ACC_ADD, OP_ACC_ADD_U,
                           OP_ACC_SUB, OP_ACC_SUB_U};
   endfunction : hilo_op

   logic [31:0] gpr_mem [NREGS];
   mdd_wb_t wb_reg, wb_next, mulw_reg, mulw_next;
   mdd_state_t st_reg, st_next;
   logic [31:0] upper_reg, bot_reg;
   logic mdu_stall_reg;
   logic addr_valid_reg, addr_store_reg;
   logic [31:0] data_addr_reg;
   logic [32:0] ah_reg;
   logic [16:0] bh_reg;
   logic [63:0] part_reg;
   mdd_op_t op_reg;
   logic [4:0] dst_reg;
   logic [32:0] rem_reg;
   logic [31:0] quo_reg, dvs_reg;
   logic [5:0] it_reg, cnt_reg;
   logic qneg_reg, rneg_reg;

   logic [31:0] opa, opb, alu_res, ea, mag_a, mag_b;
   logic mdu_op, take_mdu, take_alu, sgn, one_pass, mul_op, quot_op, div_done, port_op;
   logic fit8, fit16, fit24;
   logic [32:0] a33, b33;
   logic [63:0] acc, prod1, hi_p, prod2;
   logic [5:0] skip, rpt;
   logic [64:0] dstart, dstep;
   logic [32:0] rem_now;
   logic [31:0] quo_now, qfix, rfix;

   // register file reads with bypass of the word being written back
   assign opa = rd_port(iss_i.src_a, wb_reg, gpr_mem[iss_i.src_a]);
   assign opb = rd_port(iss_i.src_b, wb_reg, gpr_mem[iss_i.src_b]);

   assign mdu_op = iss_i.op >= OP_RD_UPPER;
   // only ops that hand a word to the write port wait out a pending product
   assign port_op = (iss_i.op >= OP_ADD && iss_i.op <= OP_CNT_ONE) ||
                    iss_i.op == OP_RD_UPPER || iss_i.op == OP_RD_BOTTOM;
   assign take_mdu = iss_i.valid && mdu_op && !mdu_stall_reg &&
                     !(mulw_reg.valid && port_op);
   assign take_alu = iss_i.valid && !mdu_op && iss_i.op != OP_NOP &&
                     !(mulw_reg.valid && port_op);
   assign sgn = iss_i.op inside {OP_PROD_PAIR, OP_ACC_ADD, OP_ACC_SUB, OP_PROD_GPR,
                                 OP_QUOT};
   assign mul_op = hilo_op(iss_i.op) || iss_i.op == OP_PROD_GPR;
   assign quot_op = iss_i.op == OP_QUOT || iss_i.op == OP_QUOT_U;

   always_comb begin
      alu_res = 32'h0;
      case (iss_i.op)
         OP_ADD: alu_res = opa + opb;
         OP_SUB: alu_res = opa - opb;
         OP_AND: alu_res = opa & opb;
         OP_OR: alu_res = opa | opb;
         OP_XOR: alu_res = opa ^ opb;
         OP_NOR: alu_res = ~(opa | opb);
         OP_SLL: alu_res = opa << opb[4:0];
         OP_SRL: alu_res = opa >> opb[4:0];
         OP_SRA: alu_res = $signed(opa) >>> opb[4:0];
         OP_CNT_ZERO: alu_res = {26'h0, lead_cnt(opa)};
         OP_CNT_ONE: alu_res = {26'h0, lead_cnt(~opa)};
         OP_RD_UPPER: alu_res = upper_reg;
         OP_RD_BOTTOM: alu_res = bot_reg;
         default: alu_res = 32'h0;
      endcase
   end

   // data address adder, apart from any instruction address logic
   assign ea = opa + {{16{iss_i.imm[15]}}, iss_i.imm};

   // multiplier operands; b alone decides one pass or two
   assign a33 = {sgn & opa[31], opa};
   assign b33 = {sgn & opb[31], opb};
   assign one_pass = &b33[32:15] || ~|b33[32:15];
   assign acc = {upper_reg, bot_reg};
   assign prod1 = one_pass ? mul_pass(a33, b33[16:0])
                           : mul_pass(a33, {1'b0, b33[15:0]});
   assign hi_p = mul_pass(ah_reg, bh_reg);
   assign prod2 = part_reg + {hi_p[47:0], 16'h0};

   // early-in: sign extension of the dividend picks steps skipped
   assign fit8 = sgn ? (&opa[31:7] || ~|opa[31:7]) : ~|opa[31:8];
   assign fit16 = sgn ? (&opa[31:15] || ~|opa[31:15]) : ~|opa[31:16];
   assign fit24 = sgn ? (&opa[31:23] || ~|opa[31:23]) : ~|opa[31:24];
   always_comb begin
      if (fit8) begin
         skip = `MDD_DIV_SKIP8;
         rpt = `MDD_DIV_RPT8;
      end else if (fit16) begin
         skip = `MDD_DIV_SKIP16;
         rpt = `MDD_DIV_RPT16;
      end else if (fit24) begin
         skip = `MDD_DIV_SKIP24;
         rpt = `MDD_DIV_RPT24;
      end else begin
         skip = `MDD_DIV_SKIP32;
         rpt = `MDD_DIV_RPT32;
      end
   end
   assign mag_a = (sgn && opa[31]) ? -opa : opa;
   assign mag_b = (sgn && opb[31]) ? -opb : opb;
   // first quotient bit is taken in the issue cycle itself
   assign dstart = div_step(33'h0, mag_a << skip, mag_b);
   assign dstep = div_step(rem_reg, quo_reg, dvs_reg);
   assign rem_now = (it_reg != 6'h0) ? dstep[64:32] : rem_reg;
   assign quo_now = (it_reg != 6'h0) ? dstep[31:0] : quo_reg;
   assign qfix = qneg_reg ? -quo_now : quo_now;
   assign rfix = rneg_reg ? -rem_now[31:0] : rem_now[31:0];
   assign div_done = st_reg == ST_DIV && cnt_reg == 6'h01;

   // the unit never looks at integer pipeline stalls
   always_comb begin
      st_next = st_reg;
      unique case (st_reg)
         ST_IDLE: begin
            if (take_mdu && mul_op && !one_pass) st_next = ST_MUL2;
            else if (take_mdu && quot_op) st_next = ST_DIV;
         end
         ST_MUL2: st_next = ST_IDLE;
         ST_DIV: begin
            if (cnt_reg == 6'h01) st_next = ST_DIV == st_reg ? ST_IDLE : st_reg;
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_reg <= ST_IDLE;
         mdu_stall_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         mdu_stall_reg <= st_next != ST_IDLE;
      end
   end

   // second-pass operands and divider state
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ah_reg <= 33'h0;
         bh_reg <= 17'h0;
         part_reg <= 64'h0;
         op_reg <= OP_NOP;
         dst_reg <= 5'h0;
      end else if (take_mdu) begin
         ah_reg <= a33;
         bh_reg <= b33[32:16];
         part_reg <= prod1;
         op_reg <= iss_i.op;
         dst_reg <= iss_i.dst;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rem_reg <= 33'h0;
         quo_reg <= 32'h0;
         dvs_reg <= 32'h0;
         it_reg <= 6'h0;
         cnt_reg <= 6'h0;
         qneg_reg <= 1'b0;
         rneg_reg <= 1'b0;
      end else if (take_mdu && quot_op) begin
         rem_reg <= dstart[64:32];
         quo_reg <= dstart[31:0];
         dvs_reg <= mag_b;
         it_reg <= `MDD_DIV_BITS - skip - 6'h01;
         cnt_reg <= rpt - 6'h01;
         qneg_reg <= sgn & (opa[31] ^ opb[31]);
         rneg_reg <= sgn & opa[31];
      end else if (st_reg == ST_DIV) begin
         rem_reg <= rem_now;
         quo_reg <= quo_now;
         if (it_reg != 6'h0) it_reg <= it_reg - 6'h01;
         cnt_reg <= cnt_reg - 6'h01;
      end
   end

   // upper/bottom result pair
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         upper_reg <= 32'h0;
         bot_reg <= 32'h0;
      end else if (take_mdu && hilo_op(iss_i.op) && one_pass) begin
         {upper_reg, bot_reg} <= hilo_upd(iss_i.op, acc, prod1);
      end else if (st_reg == ST_MUL2 && hilo_op(op_reg)) begin
         {upper_reg, bot_reg} <= hilo_upd(op_reg, acc, prod2);
      end else if (div_done) begin
         {upper_reg, bot_reg} <= {rfix, qfix};
      end
   end

   // product to register skips the bottom register, one extra stage
   always_comb begin
      mulw_next = '0;
      if (take_mdu && iss_i.op == OP_PROD_GPR && one_pass) begin
         mulw_next = '{valid: 1'b1, idx: iss_i.dst, data: prod1[31:0]};
      end else if (st_reg == ST_MUL2 && op_reg == OP_PROD_GPR) begin
         mulw_next = '{valid: 1'b1, idx: dst_reg, data: prod2[31:0]};
      end
   end

   // single write port: a pending product owns it for that cycle
   always_comb begin
      wb_next = '0;
      if (mulw_reg.valid) begin
         wb_next = mulw_reg;
      end else if ((take_alu && iss_i.op <= OP_CNT_ONE) ||
                   (take_mdu && (iss_i.op == OP_RD_UPPER || iss_i.op == OP_RD_BOTTOM))) begin
         wb_next = '{valid: 1'b1, idx: iss_i.dst, data: alu_res};
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mulw_reg <= '0;
         wb_reg <= '0;
      end else begin
         mulw_reg <= mulw_next;
         wb_reg <= wb_next;
      end
   end

   // storage only; contents undefined until written
   always_ff @(posedge clk_i) begin
      if (wb_reg.valid) gpr_mem[wb_reg.idx] <= wb_reg.data;
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         addr_valid_reg <= 1'b0;
         addr_store_reg <= 1'b0;
         data_addr_reg <= 32'h0;
      end else begin
         addr_valid_reg <= take_alu && (iss_i.op == OP_LOAD || iss_i.op == OP_STORE);
         addr_store_reg <= iss_i.op == OP_STORE;
         data_addr_reg <= ea;
      end
   end

   assign mdu_stall_o = mdu_stall_reg;
   assign port_stall_o = mulw_reg.valid;
   assign wb_o = wb_reg;
   assign addr_valid_o = addr_valid_reg;
   assign addr_store_o = addr_store_reg;
   assign data_addr_o = data_addr_reg;

   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence div8_busy;
      ##1 mdu_stall_o [*8] ##1 mdu_stall_o ##1 mdu_stall_o ##1 !mdu_stall_o;
   endsequence
   sequence mul_long_busy;
      ##1 mdu_stall_o ##1 !mdu_stall_o;
   endsequence

   div_repeat_a: assert property (take_mdu && quot_op && fit8 |-> div8_busy)
      else $error("8-bit division busy time wrong");
   long_mul_a: assert property (take_mdu && mul_op && !one_pass |-> mul_long_busy)
      else $error("long multiply repeat rate wrong");
   short_mul_a: assert property (take_mdu && mul_op && one_pass |=> !mdu_stall_o)
      else $error("short multiply stalled the unit");
   alu_lat_a: assert property (take_alu && iss_i.op == OP_ADD |=>
                               wb_o.valid && wb_o.data == $past(opa) + $past(opb))
      else $error("add result not written back next cycle");
   mulgpr_lat_a: assert property (take_mdu && iss_i.op == OP_PROD_GPR && one_pass |->
                                  ##2 wb_o.valid && wb_o.idx == $past(iss_i.dst, 2))
      else $error("short product to register latency wrong");
   addr_sum_a: assert property (take_alu && iss_i.op == OP_LOAD |=>
                                addr_valid_o && data_addr_o == $past(ea))
      else $error("data address wrong");
   clz_zero_a: assert property (take_alu && iss_i.op == OP_CNT_ZERO && opa == 32'h0 |=>
                                wb_o.data == 32'h20)
      else $error("leading zero count of zero wrong");
   bypass_fwd_a: assert property (wb_reg.valid && iss_i.src_a == wb_reg.idx |=>
                                  gpr_mem[$past(iss_i.src_a)] == $past(opa))
      else $error("operand not bypassed");
   acc_add_a: assert property (take_mdu && iss_i.op == OP_ACC_ADD && one_pass |=>
                               {upper_reg, bot_reg} == $past(acc) + $past(prod1))
      else $error("accumulate add result wrong");
   div_hold_a: assert property (st_reg == ST_DIV && cnt_reg > 6'h01 |=>
                                $stable(upper_reg) && $stable(bot_reg))
      else $error("result pair changed mid division");
endmodule : mdd_datapath
`default_nettype wire

// *** tb/mdd_issue_model.sv ***
// issue stage model that presents instructions to the datapath and re-presents refused ones
`timescale 1ns/1ns
`default_nettype none
module mdd_issue_model
   import mdd_pkg::*;
(
   input wire logic clk_i,
   input wire logic mdu_stall_i,
   input wire logic port_stall_i,
   input wire logic [31:0] cyc_i,
   output var mdd_issue_t iss_o
);
   initial iss_o = '0;

   // holds every field until an edge takes it and the next op replaces it;
   // t is the stamp of the taking edge
   task automatic send(input mdd_issue_t ins, output logic [31:0] t);
      logic muldiv_unit;
      logic wr;
      muldiv_unit = ins.op >= OP_RD_UPPER;
      // only ops that hand a word to the write port wait out a pending product
      wr = (ins.op >= OP_ADD && ins.op <= OP_CNT_ONE) ||
           ins.op == OP_RD_UPPER || ins.op == OP_RD_BOTTOM;
      t = '0;
      iss_o <= ins;
      for (int k = 0; k < 40; k++) begin
         @(posedge clk_i);
         if (!(wr && port_stall_i) && !(muldiv_unit && mdu_stall_i)) begin
            t = cyc_i;
            break;
         end
      end
   endtask : send

   // released fields flip so a stale operand never looks like a fresh one
   task automatic rest;
      mdd_issue_t idle;
      idle = mdd_issue_t'(~iss_o);
      idle.valid = 1'b0;
      iss_o <= idle;
   endtask : rest
endmodule : mdd_issue_model
`default_nettype wire

// *** tb/test_multiply_divide_datapath.sv ***
// self-checking bench of the multiply/divide execution datapath
`timescale 1ns/1ns
`default_nettype none
module test_multiply_divide_datapath;
   import mdd_pkg::*;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   mdd_issue_t iss_i;
   mdd_wb_t wb_o;
   logic mdu_stall_o, port_stall_o, addr_valid_o, addr_store_o;
   logic [31:0] data_addr_o;
   logic [31:0] cyc = '0;
   logic [31:0] last_t = '0;
   logic [31:0] prev_t = '0;
   logic [31:0] rf [32];
   logic [63:0] pair = '0;
   mdd_wb_t wexp [logic [31:0]];
   logic [32:0] aexp [logic [31:0]];
   int error_cnt = 0;
   int checked = 0;

   initial begin
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) cyc <= cyc + 32'h1;

   mdd_datapath dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .iss_i(iss_i),
      .mdu_stall_o(mdu_stall_o), .port_stall_o(port_stall_o), .wb_o(wb_o),
      .addr_valid_o(addr_valid_o), .addr_store_o(addr_store_o), .data_addr_o(data_addr_o));
   mdd_issue_model pm (.clk_i(clk_i), .mdu_stall_i(mdu_stall_o), .port_stall_i(port_stall_o),
      .cyc_i(cyc), .iss_o(iss_i));

   task automatic cmp_wb(input mdd_wb_t got, input mdd_wb_t exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_wb

   task automatic cmp_addr(input logic [32:0] got, input logic [32:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_addr

   task automatic cmp_gap(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_gap

   task automatic end_of_test;
      if (error_cnt == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test

   function automatic logic [63:0] prod(input logic u, input logic [31:0] a, input logic [31:0] b);
      logic [63:0] ea, eb;
      ea = {u ? 32'h0 : {32{a[31]}}, a};
      eb = {u ? 32'h0 : {32{b[31]}}, b};
      return ea * eb;
   endfunction : prod

   function automatic logic shortb(input logic u, input logic [31:0] b);
      return u ? b[31:15] == 17'h0 : b[31:15] == {17{b[15]}};
   endfunction : shortb

   // repeat rate by dividend width: 11, 18, 25, else 32
   function automatic logic [31:0] drpt(input logic u, input logic [31:0] a);
      logic [31:0] s;
      for (int w = 8; w < 32; w += 8) begin
         s = u ? a >> w : 32'($signed(a) >>> (w - 1));
         if (s == 32'h0 || (!u && s == 32'hffffffff)) return 32'(w / 8 * 7 + 4);
      end
      return 32'h20;
   endfunction : drpt

   function automatic logic [31:0] alu(input mdd_op_t op, input logic [31:0] a, input logic [31:0] b);
      int k;
      k = 0;
      case (op)
         OP_ADD: return a + b;
         OP_SUB: return a - b;
         OP_AND: return a & b;
         OP_OR: return a | b;
         OP_XOR: return a ^ b;
         OP_NOR: return ~(a | b);
         OP_SLL: return a << b[4:0];
         OP_SRL: return a >> b[4:0];
         OP_SRA: return 32'($signed(a) >>> b[4:0]);
         OP_RD_UPPER: return pair[63:32];
         OP_RD_BOTTOM: return pair[31:0];
         default: begin
            while (k < 32 && a[31 - k] == (op == OP_CNT_ONE)) k++;
            return 32'(k);
         end
      endcase
   endfunction : alu

   // issues one op and files its expected result under the stamp it is due
   task automatic do_op(input mdd_op_t op, input int a, input int b, input int d,
                        input logic [15:0] imm = 16'h0);
      mdd_issue_t ins;
      logic [31:0] va, vb, n;
      logic u;
      logic [63:0] p;
      va = rf[a];
      vb = rf[b];
      u = op inside {OP_PROD_PAIR_U, OP_ACC_ADD_U, OP_ACC_SUB_U, OP_QUOT_U};
      p = prod(u, va, vb);
      ins = '{1'b1, op, 5'(a), 5'(b), 5'(d), imm};
      pm.send(ins, n);
      prev_t = last_t;
      last_t = n;
      case (op)
         OP_LOAD, OP_STORE: aexp[n + 1] = {op == OP_STORE, va + {{16{imm[15]}}, imm}};
         OP_PROD_PAIR, OP_PROD_PAIR_U: pair = p;
         OP_ACC_ADD, OP_ACC_ADD_U: pair = pair + p;
         OP_ACC_SUB, OP_ACC_SUB_U: pair = pair - p;
         OP_QUOT: pair = {32'($signed(va) % $signed(vb)), 32'($signed(va) / $signed(vb))};
         OP_QUOT_U: pair = {va % vb, va / vb};
         OP_PROD_GPR: begin
            rf[d] = p[31:0];
            wexp[n + (shortb(u, vb) ? 2 : 3)] = '{1'b1, 5'(d), p[31:0]};
         end
         default: begin
            rf[d] = alu(op, va, vb);
            wexp[n + 1] = '{1'b1, 5'(d), rf[d]};
         end
      endcase
   endtask : do_op

   always @(posedge clk_i) begin
      if (!sys_rst_i) begin
         if (wexp.exists(cyc)) begin
            cmp_wb(wb_o, wexp[cyc]);
            wexp.delete(cyc);
         end else if (wb_o.valid !== 1'b0) begin
            cmp_wb(wb_o, '0);
         end
         if (aexp.exists(cyc)) begin
            cmp_addr({addr_store_o, data_addr_o}, aexp[cyc]);
            cmp_addr({32'h0, addr_valid_o}, 33'h1);
            aexp.delete(cyc);
         end else if (addr_valid_o !== 1'b0) begin
            cmp_addr({32'h0, addr_valid_o}, 33'h0);
         end
      end
   end

   // registers are not reset, so constants are grown from the cleared pair
   task automatic t_alu;
      logic [31:0] s;
      do_op(OP_RD_UPPER, 0, 0, 0);
      s = last_t;
      do_op(OP_NOR, 0, 0, 1);
      do_op(OP_SRL, 1, 1, 2);
      do_op(OP_ADD, 2, 2, 3);
      do_op(OP_SLL, 3, 2, 4);
      do_op(OP_SLL, 2, 4, 5);
      do_op(OP_ADD, 5, 2, 6);
      do_op(OP_SLL, 3, 3, 7);
      do_op(OP_ADD, 7, 2, 8);
      do_op(OP_SRL, 1, 6, 9);
      do_op(OP_SRL, 1, 8, 10);
      do_op(OP_SRL, 1, 2, 11);
      do_op(OP_SLL, 2, 1, 12);
      do_op(OP_SRA, 12, 5, 13);
      do_op(OP_SUB, 9, 11, 14);
      do_op(OP_XOR, 14, 13, 15);
      do_op(OP_AND, 14, 10, 16);
      do_op(OP_OR, 12, 9, 17);
      do_op(OP_CNT_ZERO, 9, 0, 18);
      do_op(OP_CNT_ONE, 13, 0, 19);
      do_op(OP_CNT_ZERO, 0, 0, 20);
      do_op(OP_CNT_ONE, 1, 0, 31);
      cmp_gap(last_t - s, 32'h15);
      do_op(OP_LOAD, 31, 0, 0, 16'hfff0);
      do_op(OP_STORE, 12, 0, 0, 16'h7fff);
   endtask : t_alu

   task automatic t_mul;
      do_op(OP_PROD_PAIR, 12, 1, 0);
      do_op(OP_PROD_PAIR_U, 12, 9, 0);
      cmp_gap(last_t - prev_t, 32'h1);
      do_op(OP_RD_UPPER, 0, 0, 21);
      cmp_gap(last_t - prev_t, 32'h1);
      do_op(OP_RD_BOTTOM, 0, 0, 22);
      do_op(OP_PROD_PAIR, 9, 11, 0);
      do_op(OP_PROD_PAIR_U, 9, 1, 0);
      cmp_gap(last_t - prev_t, 32'h2);
      do_op(OP_RD_BOTTOM, 0, 0, 23);
      cmp_gap(last_t - prev_t, 32'h2);
      do_op(OP_ACC_ADD, 11, 13, 0);
      do_op(OP_ACC_SUB_U, 12, 11, 0);
      do_op(OP_ACC_ADD_U, 14, 9, 0);
      do_op(OP_ACC_SUB, 13, 14, 0);
      do_op(OP_RD_UPPER, 0, 0, 24);
      do_op(OP_RD_BOTTOM, 0, 0, 25);
   endtask : t_mul

   task automatic t_gpr;
      do_op(OP_PROD_GPR, 11, 11, 26);
      do_op(OP_ADD, 2, 3, 27);
      cmp_gap(last_t - prev_t, 32'h1);
      do_op(OP_ADD, 3, 3, 28);
      cmp_gap(last_t - prev_t, 32'h2);
      do_op(OP_PROD_GPR, 9, 13, 29);
      do_op(OP_PROD_GPR, 13, 9, 24);
      cmp_gap(last_t - prev_t, 32'h1);
      do_op(OP_SUB, 3, 2, 30);
      cmp_gap(last_t - prev_t, 32'h2);
      do_op(OP_PROD_GPR, 11, 12, 25);
      do_op(OP_PROD_GPR, 12, 11, 23);
      cmp_gap(last_t - prev_t, 32'h2);
      do_op(OP_RD_BOTTOM, 0, 0, 22);
   endtask : t_gpr

   task automatic t_div;
      int a [6] = '{1, 13, 10, 14, 7, 1};
      int b [6] = '{3, 8, 6, 8, 3, 8};
      for (int i = 0; i < 6; i++) begin
         do_op(i < 4 ? OP_QUOT : OP_QUOT_U, a[i], b[i], 0);
         do_op(OP_RD_BOTTOM, 0, 0, 26);
         cmp_gap(last_t - prev_t, drpt(i > 3, rf[a[i]]));
         do_op(OP_RD_UPPER, 0, 0, 27);
      end
      do_op(OP_QUOT, 14, 3, 0);
      do_op(OP_XOR, 2, 3, 28);
      cmp_gap(last_t - prev_t, 32'h1);
      do_op(OP_PROD_PAIR, 2, 3, 0);
      cmp_gap(last_t - prev_t, 32'h1f);
      do_op(OP_RD_BOTTOM, 0, 0, 29);
   endtask : t_div

   initial begin
      repeat (5000) @(posedge clk_i);
      error_cnt++;
      end_of_test();
   end

   initial begin
      repeat (12) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      t_alu();
      t_mul();
      t_gpr();
      t_div();
      pm.rest();
      repeat (40) @(posedge clk_i);
      cmp_gap(32'(wexp.size() + aexp.size()), 32'h0);
      end_of_test();
   end
endmodule : test_multiply_divide_datapath
`default_nettype wire
